/* File: nvcc_pkg.sv */
// ============================================================
// register map
// ============================================================
package nvcc_pkg;

    // register indices; byte address is four times the index
    localparam logic [15:0] NVCC_CTRL_IDX = 16'h400a;
    localparam logic [15:0] NVCC_STAT_IDX = 16'h4012;
    localparam logic [15:0] NVCC_MASK_IDX = 16'h401a;
    localparam logic [15:0] NVCC_KEY_IDX = 16'h4008;
    localparam int NVCC_AW = 18;
    localparam logic [17:0] NVCC_CTRL_ADDR = {NVCC_CTRL_IDX, 2'h0};
    localparam logic [17:0] NVCC_STAT_ADDR = {NVCC_STAT_IDX, 2'h0};
    localparam logic [17:0] NVCC_MASK_ADDR = {NVCC_MASK_IDX, 2'h0};
    localparam logic [17:0] NVCC_KEY_ADDR = {NVCC_KEY_IDX, 2'h0};

    // ========================================================
    // control register fields
    // ========================================================
    localparam int NVCC_PROG_BIT = 15;
    localparam int NVCC_SRC_BIT = 13;
    localparam int NVCC_FINAL_BIT = 11;
    localparam int NVCC_VERIFY_BIT = 10;
    localparam int NVCC_WRITE_BIT = 9;
    localparam int NVCC_READ_BIT = 8;
    localparam int NVCC_MARGIN_LSB = 6;
    localparam int NVCC_BULK_BIT = 5;
    localparam int NVCC_PAGE_LSB = 0;
    localparam logic NVCC_SRC_RST = 1'b1;
    localparam logic [1:0] NVCC_MARGIN_RST = 2'h0;
    localparam logic [1:0] NVCC_PAGE_RST = 2'h0;

    // status and mask fields
    localparam int NVCC_DONE_BIT = 5;
    localparam int NVCC_FAIL_BIT = 4;
    localparam logic NVCC_MASK_RST = 1'b1;

    // page numbering
    localparam logic [2:0] NVCC_EE_PAGE_BASE = 3'h2;
    localparam logic [1:0] NVCC_EE_PAGE_RSVD = 2'h3;
    localparam logic [2:0] NVCC_USER_PAGE_LO = 3'h2;
    localparam logic [2:0] NVCC_USER_PAGE_HI = 3'h3;

    // ========================================================
    // types
    // ========================================================
    typedef enum logic [1:0] {
        NVCC_CMD_READ,
        NVCC_CMD_WRITE,
        NVCC_CMD_VERIFY,
        NVCC_CMD_FINAL
    } nvcc_cmd_t;

    typedef enum logic [1:0] {
        NVCC_IDLE,
        NVCC_CHECK,
        NVCC_WAIT,
        NVCC_NEXT
    } nvcc_fsm_t;

    // request to the memory engine
    typedef struct packed {
        logic req;
        nvcc_cmd_t cmd;
        logic array_sel;
        logic all_pages;
        logic [2:0] page;
        logic [1:0] margin;
    } nvcc_mreq_t;

endpackage

/* File: nvcc_ctrl.sv */
// Functional notes
// [R1] bit 15 one enters program state; zero ignored
// [R2] program state lasts until device reset
// [R3] protected fields need the key first
// [R4] bit 13, reset one: array 1, eeprom 0
// [R5] bit 11 finalises, locking user pages
// [R6] bit 10 verifies pages against window
// [R7] bit 9 programs pages from window
// [R8] bit 8 loads pages into window
// [R9] bits 7:6 margin for array read, verify
// [R10] bit 5 all pages, else page field
// [R11] array page codes are pages zero to three
// [R12] eeprom codes 0-2 are pages two to four; 3 reserved
// [R13] done flag, bit 5: command or auto program end
// [R14] fail flag, bit 4: read fail, mismatch, locked write
// [R15] flags set on rising event, held, cleared by one
// [R16] unmasked flag raises memory interrupt
// [R17] mask bits 5, 4 reset one; one masks
// [R18] read launch has program and unused bits zero
// [R19] bulk array write does pages two, three, raises fail
// [R20] one command at a time; done after completion
`timescale 1ns/100ps
`default_nettype none

module nvcc_ctrl
    import nvcc_pkg::*;
#(
    // unlock code; value is arbitrary
    parameter logic [15:0] KEY_CODE = 16'h5a3c
) (
    // clock, reset, enable
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    // avalon-mm slave
    input wire logic [NVCC_AW-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // memory engine
    output nvcc_mreq_t mem_req_out,
    input wire logic mem_done_in,
    input wire logic mem_fail_in,
    input wire logic auto_prog_done_in,
    input wire logic user_lock_in,
    // status
    output logic program_state_out,
    output logic mem_irq_out
);

    // ========================================================
    // state
    // ========================================================
    typedef struct packed {
        nvcc_fsm_t fsm;
        logic prog;
        logic unlocked;
        logic array_sel;
        logic [1:0] margin;
        logic bulk;
        logic [1:0] page;
        nvcc_cmd_t cmd;
        logic busy;
        logic second;
        logic soft_fail;
        logic finalised;
        nvcc_mreq_t mreq;
        logic done_evt;
        logic fail_evt;
        logic done_q;
        logic fail_q;
        logic done_flag;
        logic fail_flag;
        logic done_mask;
        logic fail_mask;
        logic ack;
        logic [31:0] rdata;
    } nvcc_state_t;

    localparam nvcc_state_t ST_RST = '{
        fsm: NVCC_IDLE,
        prog: 1'b0,
        unlocked: 1'b0,
        array_sel: NVCC_SRC_RST,
        margin: NVCC_MARGIN_RST,
        bulk: 1'b0,
        page: NVCC_PAGE_RST,
        cmd: NVCC_CMD_READ,
        busy: 1'b0,
        second: 1'b0,
        soft_fail: 1'b0,
        finalised: 1'b0,
        mreq: '0,
        done_evt: 1'b0,
        fail_evt: 1'b0,
        done_q: 1'b0,
        fail_q: 1'b0,
        done_flag: 1'b0,
        fail_flag: 1'b0,
        done_mask: NVCC_MASK_RST,
        fail_mask: NVCC_MASK_RST,
        ack: 1'b0,
        rdata: 32'h0
    };

    nvcc_state_t state_ff;
    nvcc_state_t nxt_state;

    // ========================================================
    // helpers
    // ========================================================
    // register address match
    function automatic logic hit(input logic [NVCC_AW-1:0] a,
                                 input logic [NVCC_AW-1:0] r);
        hit = (a == r);
    endfunction

    // page code to physical page
    function automatic logic [2:0] phys_page(input logic arr,
                                             input logic [1:0] code);
        if (arr) begin
            phys_page = {1'b0, code}; // [R11]
        end else begin
            phys_page = NVCC_EE_PAGE_BASE + {1'b0, code}; // [R12]
        end
    endfunction

    // ========================================================
    // bus decode
    // ========================================================
    logic bus_req;
    logic wr_go;
    logic [15:0] wmask;
    logic [15:0] wd;
    logic hit_ctrl;
    logic hit_stat;
    logic hit_mask;
    logic hit_key;

    // one wait state so read data always comes from a flop
    assign bus_req = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = bus_req & ~state_ff.ack;
    assign wr_go = avs_write_in & state_ff.ack & clk_en_in;
    assign wmask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
    assign wd = avs_writedata_in[15:0] & wmask;
    assign hit_ctrl = hit(avs_address_in, NVCC_CTRL_ADDR);
    assign hit_stat = hit(avs_address_in, NVCC_STAT_ADDR);
    assign hit_mask = hit(avs_address_in, NVCC_MASK_ADDR);
    assign hit_key = hit(avs_address_in, NVCC_KEY_ADDR);

    // ========================================================
    // next state
    // ========================================================
    always_comb begin
        logic [3:0] cmd_bits;
        logic [15:0] rd;
        logic done_rise;
        logic fail_rise;
        cmd_bits = 4'h0;
        rd = 16'h0;
        done_rise = 1'b0;
        fail_rise = 1'b0;
        nxt_state = state_ff;
        if (clk_en_in) begin
            // bus handshake and read capture
            nxt_state.ack = bus_req & ~state_ff.ack;
            if (state_ff.busy) begin
                cmd_bits[state_ff.cmd] = 1'b1;
            end
            if (hit_ctrl) begin
                rd[NVCC_PROG_BIT] = state_ff.prog;
                rd[NVCC_SRC_BIT] = state_ff.array_sel;
                rd[NVCC_FINAL_BIT] = cmd_bits[NVCC_CMD_FINAL];
                rd[NVCC_VERIFY_BIT] = cmd_bits[NVCC_CMD_VERIFY];
                rd[NVCC_WRITE_BIT] = cmd_bits[NVCC_CMD_WRITE];
                rd[NVCC_READ_BIT] = cmd_bits[NVCC_CMD_READ];
                rd[NVCC_MARGIN_LSB+:2] = state_ff.margin;
                rd[NVCC_BULK_BIT] = state_ff.bulk;
                rd[NVCC_PAGE_LSB+:2] = state_ff.page;
            end else if (hit_stat) begin
                rd[NVCC_DONE_BIT] = state_ff.done_flag;
                rd[NVCC_FAIL_BIT] = state_ff.fail_flag;
            end else if (hit_mask) begin
                rd[NVCC_DONE_BIT] = state_ff.done_mask;
                rd[NVCC_FAIL_BIT] = state_ff.fail_mask;
            end else if (hit_key) begin
                rd[0] = state_ff.unlocked;
            end
            if (avs_read_in & ~state_ff.ack) begin
                nxt_state.rdata = {16'h0, rd};
            end

            // event pulses default low
            nxt_state.done_evt = 1'b0;
            nxt_state.fail_evt = 1'b0;

            // right key unlocks, other values relock
            if (wr_go && hit_key && (&avs_byteenable_in[1:0])) begin
                nxt_state.unlocked = (avs_writedata_in[15:0] == KEY_CODE);
            end

            // control register write
            if (wr_go && hit_ctrl) begin
                if (avs_byteenable_in[0]) begin
                    nxt_state.bulk = wd[NVCC_BULK_BIT]; // [R10]
                    nxt_state.page = wd[NVCC_PAGE_LSB+:2];
                end
                // protected fields need the key first
                if (state_ff.unlocked) begin // [R3]
                    if (avs_byteenable_in[0]) begin
                        nxt_state.margin = wd[NVCC_MARGIN_LSB+:2]; // [R9]
                    end
                    if (avs_byteenable_in[1]) begin
                        nxt_state.array_sel = wd[NVCC_SRC_BIT]; // [R4]
                        // only a one has effect, only reset clears it
                        if (wd[NVCC_PROG_BIT]) begin
                            nxt_state.prog = 1'b1; // [R1] [R2]
                        end
                    end
                    // launch only from program state when idle
                    if (avs_byteenable_in[1] && state_ff.prog &&
                        !state_ff.busy) begin // [R20]
                        nxt_state.busy = 1'b1;
                        nxt_state.fsm = NVCC_CHECK;
                        nxt_state.soft_fail = 1'b0;
                        nxt_state.second = 1'b0;
                        if (wd[NVCC_FINAL_BIT]) begin
                            nxt_state.cmd = NVCC_CMD_FINAL; // [R5]
                        end else if (wd[NVCC_VERIFY_BIT]) begin
                            nxt_state.cmd = NVCC_CMD_VERIFY; // [R6]
                        end else if (wd[NVCC_WRITE_BIT]) begin
                            nxt_state.cmd = NVCC_CMD_WRITE; // [R7]
                        end else if (wd[NVCC_READ_BIT]) begin
                            nxt_state.cmd = NVCC_CMD_READ; // [R8] [R18]
                        end else begin
                            nxt_state.busy = 1'b0;
                            nxt_state.fsm = NVCC_IDLE;
                        end
                    end
                end
            end

            // command sequencer
            case (state_ff.fsm)
                NVCC_IDLE: begin
                    nxt_state.mreq.req = 1'b0;
                end
                NVCC_CHECK: begin
                    nxt_state.mreq.cmd = state_ff.cmd;
                    nxt_state.mreq.array_sel = state_ff.array_sel;
                    nxt_state.mreq.all_pages = state_ff.bulk;
                    nxt_state.mreq.page =
                        phys_page(state_ff.array_sel, state_ff.page);
                    // margin only for array reads and verifies
                    nxt_state.mreq.margin =
                        (state_ff.array_sel &&
                         state_ff.cmd != NVCC_CMD_WRITE &&
                         state_ff.cmd != NVCC_CMD_FINAL) ?
                        state_ff.margin : NVCC_MARGIN_RST; // [R9]
                    if ((state_ff.cmd == NVCC_CMD_WRITE &&
                         (state_ff.finalised || user_lock_in)) ||
                        (!state_ff.array_sel &&
                         state_ff.cmd != NVCC_CMD_READ) ||
                        (!state_ff.array_sel && !state_ff.bulk &&
                         state_ff.page == NVCC_EE_PAGE_RSVD)) begin
                        // refused command
                        nxt_state.fsm = NVCC_IDLE;
                        nxt_state.busy = 1'b0;
                        nxt_state.done_evt = 1'b1; // [R13]
                        nxt_state.fail_evt = 1'b1; // [R14] [R12]
                    end else begin
                        if (state_ff.cmd == NVCC_CMD_WRITE &&
                            state_ff.array_sel && state_ff.bulk) begin
                            // factory pages stay untouched
                            nxt_state.mreq.all_pages = 1'b0; // [R19]
                            nxt_state.mreq.page = NVCC_USER_PAGE_LO;
                            nxt_state.second = 1'b1;
                            nxt_state.soft_fail = 1'b1; // [R19]
                        end
                        nxt_state.mreq.req = 1'b1;
                        nxt_state.fsm = NVCC_WAIT;
                    end
                end
                NVCC_WAIT: begin
                    if (mem_done_in) begin
                        nxt_state.mreq.req = 1'b0;
                        if (mem_fail_in) begin
                            nxt_state.soft_fail = 1'b1;
                        end
                        if (state_ff.second) begin
                            nxt_state.second = 1'b0;
                            nxt_state.fsm = NVCC_NEXT;
                        end else begin
                            // finish only after the engine reports done
                            nxt_state.fsm = NVCC_IDLE;
                            nxt_state.busy = 1'b0; // [R20]
                            nxt_state.done_evt = 1'b1; // [R13]
                            nxt_state.fail_evt =
                                state_ff.soft_fail | mem_fail_in; // [R14]
                            if (state_ff.cmd == NVCC_CMD_FINAL &&
                                !mem_fail_in) begin
                                nxt_state.finalised = 1'b1; // [R5]
                            end
                        end
                    end
                end
                NVCC_NEXT: begin
                    // second user page of a bulk array write
                    nxt_state.mreq.page = NVCC_USER_PAGE_HI; // [R19]
                    nxt_state.mreq.req = 1'b1;
                    nxt_state.fsm = NVCC_WAIT;
                end
                default: begin
                    nxt_state.fsm = NVCC_IDLE;
                end
            endcase

            // auto program end counts as done
            if (auto_prog_done_in) begin
                nxt_state.done_evt = 1'b1; // [R13]
            end

            // edge detect on the event lines
            nxt_state.done_q = state_ff.done_evt;
            nxt_state.fail_q = state_ff.fail_evt;
            done_rise = state_ff.done_evt & ~state_ff.done_q; // [R15]
            fail_rise = state_ff.fail_evt & ~state_ff.fail_q; // [R15]

            // write one clears; a same-cycle set wins
            if (wr_go && hit_stat && avs_byteenable_in[0]) begin
                if (wd[NVCC_DONE_BIT]) begin
                    nxt_state.done_flag = 1'b0; // [R15]
                end
                if (wd[NVCC_FAIL_BIT]) begin
                    nxt_state.fail_flag = 1'b0; // [R15]
                end
            end
            if (done_rise) begin
                nxt_state.done_flag = 1'b1; // [R13]
            end
            if (fail_rise) begin
                nxt_state.fail_flag = 1'b1; // [R14]
            end

            // mask register
            if (wr_go && hit_mask && avs_byteenable_in[0]) begin
                nxt_state.done_mask = wd[NVCC_DONE_BIT]; // [R17]
                nxt_state.fail_mask = wd[NVCC_FAIL_BIT]; // [R17]
            end
        end
    end

    // ========================================================
    // state register
    // ========================================================
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= ST_RST; // [R2]
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ========================================================
    // outputs
    // ========================================================
    assign avs_readdata_out = state_ff.rdata;
    assign mem_req_out = state_ff.mreq;
    assign program_state_out = state_ff.prog;
    // masked flags stay latched but stay off the line
    assign mem_irq_out =
        (state_ff.done_flag & ~state_ff.done_mask) |
        (state_ff.fail_flag & ~state_ff.fail_mask); // [R16] [R17]

endmodule

`default_nettype wire

/* File: nvcc_chk.sv */
`timescale 1ns/100ps
`default_nettype none
// ====================
// command block checker
module nvcc_chk
    import nvcc_pkg::*;
(
    // clock, reset, enable
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    // register bus
    input wire logic [NVCC_AW-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic avs_waitrequest_out,
    // engine and status
    input wire nvcc_mreq_t mem_req_out,
    input wire logic mem_done_in,
    input wire logic user_lock_in,
    input wire logic program_state_out,
    input wire logic mem_irq_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    // control write completing
    logic ctrl_wr;
    assign ctrl_wr = avs_write_in && !avs_waitrequest_out && clk_en_in
        && (avs_address_in == NVCC_CTRL_ADDR);

    property p_prog_set;
        $rose(program_state_out) |-> $past(ctrl_wr && avs_writedata_in[15]);
    endproperty
    a_prog_set: assert property (p_prog_set) else $error("prog entry");
    property p_prog_hold;
        program_state_out |=> program_state_out;
    endproperty
    a_prog_hold: assert property (p_prog_hold) else $error("prog lost");
    property p_req_prog;
        mem_req_out.req |-> program_state_out;
    endproperty
    a_req_prog: assert property (p_req_prog) else $error("req no prog");
    property p_req_hold;
        mem_req_out.req && !mem_done_in |=>
            mem_req_out.req && $stable(mem_req_out);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("req moved");
    property p_req_end;
        mem_req_out.req && mem_done_in && clk_en_in |=> !mem_req_out.req;
    endproperty
    a_req_end: assert property (p_req_end) else $error("req stuck");
    // margin only on array read, verify
    property p_margin;
        mem_req_out.req && (!mem_req_out.array_sel ||
            mem_req_out.cmd inside {NVCC_CMD_WRITE, NVCC_CMD_FINAL})
            |-> mem_req_out.margin == 2'h0;
    endproperty
    a_margin: assert property (p_margin) else $error("bad margin");
    property p_ee_req;
        mem_req_out.req && !mem_req_out.array_sel |->
            mem_req_out.cmd == NVCC_CMD_READ && (mem_req_out.all_pages
            || mem_req_out.page inside {[3'h2:3'h4]});
    endproperty
    a_ee_req: assert property (p_ee_req) else $error("bad ee req");
    property p_locked;
        mem_req_out.req && mem_req_out.cmd == NVCC_CMD_WRITE |-> !user_lock_in;
    endproperty
    a_locked: assert property (p_locked) else $error("locked write");
    property p_ack;
        (avs_read_in || avs_write_in) && avs_waitrequest_out && clk_en_in
            |=> !avs_waitrequest_out;
    endproperty
    a_ack: assert property (p_ack) else $error("late ack");
    // masks reset set
    property p_irq_rst;
        $past(rst_in) |-> !mem_irq_out ##1 !mem_irq_out;
    endproperty
    a_irq_rst: assert property (p_irq_rst) else $error("irq at reset");

    c_prog: cover property ($rose(program_state_out));
    c_final: cover property (mem_req_out.req && mem_req_out.cmd == NVCC_CMD_FINAL);
    c_irq: cover property ($rose(mem_irq_out));
endmodule

bind nvcc_ctrl nvcc_chk i_nvcc_chk (.*);
`default_nettype wire

/* File: nvcc_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ====================
// memory engine model
module nvcc_mem_model
    import nvcc_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // request and bench settings
    input wire nvcc_mreq_t mem_req_in,
    input wire logic [3:0] delay_in,
    input wire logic fail_cfg_in,
    // answer
    output logic done_out,
    output logic fail_out,
    output logic lock_out
);
    logic [3:0] cnt_ff;
    logic ans_ff;
    logic done_ff;
    logic lock_ff;
    logic junk_ff;

    // fail is noise unless done
    assign fail_out = done_ff ? fail_cfg_in : junk_ff;
    assign done_out = done_ff;
    assign lock_out = lock_ff;

    // one answer per request, delay_in + 1 cycles after req rises
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_ff <= 4'h0;
            ans_ff <= 1'b0;
            done_ff <= 1'b0;
            lock_ff <= 1'b0;
            junk_ff <= 1'b0;
        end else begin
            junk_ff <= ~junk_ff;
            done_ff <= 1'b0;
            if (!mem_req_in.req) begin
                ans_ff <= 1'b0;
                cnt_ff <= 4'h0;
            end else if (!ans_ff && cnt_ff == delay_in) begin
                done_ff <= 1'b1;
                ans_ff <= 1'b1;
                if (mem_req_in.cmd == NVCC_CMD_FINAL && !fail_cfg_in) begin
                    lock_ff <= 1'b1;
                end
            end else if (!ans_ff) begin
                cnt_ff <= cnt_ff + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: nvcc_ctrl_bench.sv */
`timescale 1ns/100ps
`default_nettype none
// ====================
// command block bench
module nvcc_ctrl_bench
    import nvcc_pkg::*;
;
    localparam logic [15:0] UNLOCK = 16'h5a3c; // arbitrary value
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [17:0] addr = 18'h0;
    logic rd = 1'b0;
    logic wr_en = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic waitreq, mdone, mfail, ulock, prog, irq, req_q;
    logic auto = 1'b0;
    logic mfi = 1'b0;
    logic [3:0] mdly = 4'h1;
    nvcc_mreq_t mreq;
    nvcc_mreq_t seen_q[$];
    int fail_count = 0;
    int check_count = 0;

    always #2 clk = ~clk;

    nvcc_ctrl #(.KEY_CODE(UNLOCK)) i_nvcc_ctrl (
        .core_clk_in(clk), .rst_in(rst), .clk_en_in(1'b1),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr_en),
        .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
        .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
        .mem_req_out(mreq), .mem_done_in(mdone), .mem_fail_in(mfail),
        .auto_prog_done_in(auto), .user_lock_in(ulock),
        .program_state_out(prog), .mem_irq_out(irq));
    nvcc_mem_model i_nvcc_mem_model (
        .clk_in(clk), .rst_in(rst), .mem_req_in(mreq), .delay_in(mdly),
        .fail_cfg_in(mfi), .done_out(mdone), .fail_out(mfail),
        .lock_out(ulock));

    // log every new engine request
    always @(posedge clk) begin
        if (mreq.req && !req_q) begin
            seen_q.push_back(mreq);
        end
        req_q <= mreq.req;
    end

    task automatic end_sim();
        if (fail_count == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, exp, input string m);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask

    // one transfer, held until waitrequest low
    task automatic bus(input logic w, input logic [17:0] a,
        input logic [15:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        addr <= a;
        wr_en <= w;
        rd <= !w;
        wdata <= {16'h0, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 20);
        q = rdata;
        wr_en <= 1'b0;
        rd <= 1'b0;
        if (n >= 20) begin
            chk(32'h1, 32'h0, "bus hang");
            end_sim();
        end
    endtask

    task automatic wr(input logic [17:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [17:0] a, input logic [31:0] e,
        input string m);
        logic [31:0] q;
        bus(1'b0, a, 16'h0, q);
        chk(q, e, m);
    endtask

    // flags sampled mid-cycle
    task automatic pin(input logic is_irq, input logic e, input string m);
        @(negedge clk);
        chk({31'h0, is_irq ? irq : prog}, {31'h0, e}, m);
    endtask

    task automatic reset_dut();
        @(posedge clk);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
    endtask

    // launch, poll done, check requests, clear
    task automatic run(input logic [15:0] v, input logic fi, input int n,
        input nvcc_cmd_t c, input logic [2:0] pg, input logic [1:0] mg,
        input logic [31:0] st);
        logic [31:0] q;
        int k;
        seen_q.delete();
        mfi <= fi;
        mdly <= {v[1:0], 2'h1};
        wr(NVCC_CTRL_ADDR, v);
        k = 0;
        do begin
            bus(1'b0, NVCC_STAT_ADDR, 16'h0, q);
            k++;
        end while (q[NVCC_DONE_BIT] !== 1'b1 && k < 40);
        chk(q, st, "status");
        if (k >= 40) end_sim();
        chk(seen_q.size(), n, "requests");
        if (n > 0) begin
            chk({seen_q[0].cmd, seen_q[0].array_sel, seen_q[0].all_pages,
                seen_q[0].margin}, {c, v[13], v[5] && n == 1, mg}, "fields");
            if (!v[5] || n == 2) chk(seen_q[0].page, pg, "page");
        end
        if (n == 2) chk(seen_q[1].page, pg + 3'h1, "page two");
        pin(1'b1, 1'b1, "irq set");
        wr(NVCC_STAT_ADDR, 16'h0030);
        rdc(NVCC_STAT_ADDR, 32'h0, "status clear");
        pin(1'b1, 1'b0, "irq clear");
    endtask

    initial begin
        logic [31:0] q;
        reset_dut();
        rdc(NVCC_CTRL_ADDR, 32'h2000, "ctrl rst");
        rdc(NVCC_MASK_ADDR, 32'h0030, "mask rst");
        rdc(NVCC_STAT_ADDR, 32'h0, "stat rst");
        rdc(18'h00100, 32'h0, "unmapped");
        wr(18'h00100, 16'hffff);
        wr(NVCC_CTRL_ADDR, 16'h8000);
        rdc(NVCC_CTRL_ADDR, 32'h2000, "locked");
        pin(1'b0, 1'b0, "locked prog");
        wr(NVCC_KEY_ADDR, UNLOCK);
        bus(1'b0, NVCC_KEY_ADDR, 16'h0, q);
        chk(q & 32'h1, 32'h1, "unlock");
        wr(NVCC_CTRL_ADDR, 16'h2000);
        pin(1'b0, 1'b0, "prog zero");
        wr(NVCC_CTRL_ADDR, 16'ha000);
        pin(1'b0, 1'b1, "prog one");
        wr(NVCC_CTRL_ADDR, 16'h0000);
        rdc(NVCC_CTRL_ADDR, 32'h8000, "prog sticky");
        @(posedge clk);
        auto <= 1'b1;
        @(posedge clk);
        auto <= 1'b0;
        rdc(NVCC_STAT_ADDR, 32'h20, "auto done");
        pin(1'b1, 1'b0, "masked irq");
        wr(NVCC_MASK_ADDR, 16'h0000);
        pin(1'b1, 1'b1, "unmasked irq");
        wr(NVCC_STAT_ADDR, 16'h0010);
        rdc(NVCC_STAT_ADDR, 32'h20, "other bit");
        wr(NVCC_STAT_ADDR, 16'h0020);
        // launches keep program and unused bits zero
        run(16'h2482, 0, 1, NVCC_CMD_VERIFY, 3'h2, 2'h2, 32'h20);
        run(16'h24c3, 1, 1, NVCC_CMD_VERIFY, 3'h3, 2'h3, 32'h30);
        run(16'h2101, 0, 1, NVCC_CMD_READ, 3'h1, 2'h0, 32'h20);
        run(16'h0100, 0, 1, NVCC_CMD_READ, 3'h2, 2'h0, 32'h20);
        run(16'h0102, 0, 1, NVCC_CMD_READ, 3'h4, 2'h0, 32'h20);
        run(16'h0103, 0, 0, NVCC_CMD_READ, 3'h0, 2'h0, 32'h30);
        run(16'h0120, 0, 1, NVCC_CMD_READ, 3'h0, 2'h0, 32'h20);
        run(16'h0202, 0, 0, NVCC_CMD_WRITE, 3'h0, 2'h0, 32'h30);
        run(16'h2203, 0, 1, NVCC_CMD_WRITE, 3'h3, 2'h0, 32'h20);
        run(16'h2220, 0, 2, NVCC_CMD_WRITE, 3'h2, 2'h0, 32'h30);
        run(16'h2802, 0, 1, NVCC_CMD_FINAL, 3'h2, 2'h0, 32'h20);
        run(16'h2202, 0, 0, NVCC_CMD_WRITE, 3'h0, 2'h0, 32'h30);
        reset_dut();
        pin(1'b0, 1'b0, "prog reset");
        rdc(NVCC_MASK_ADDR, 32'h0030, "mask reset");
        end_sim();
    end
endmodule
`default_nettype wire
